//--- bench/stc_host_model.sv
// Host controller model that drives the trigger pin
`timescale 1ns/1ps
`default_nettype none
module stc_host_model (
	input wire logic sys_clk_i,
	output var logic scan_request_pin_n_o
);

	// ----------------------------------------
	// Trigger pin driver
	// ----------------------------------------
	initial scan_request_pin_n_o = 1'b1;

	// Set the pin level right after an edge and hold it for n cycles
	task automatic hold(input logic lvl, input int n);
		scan_request_pin_n_o <= lvl;
		repeat (n) @(posedge sys_clk_i);
	endtask : hold

endmodule : stc_host_model
`default_nettype wire

//--- bench/tb_top.sv
// Self-checking testbench for the scan trigger control
`timescale 1ns/1ps
`default_nettype none
module tb_top import stc_pkg::*;;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam int Q = 20;
	localparam int T = 200;
	logic sys_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	stc_apb_req_type req = '0;
	logic decode_good_i = 1'b0;
	logic decode_error_i = 1'b0;
	logic pin_n;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic session_active_o;
	logic illumination_o;
	logic pwm;
	logic ind_a;
	logic ind_b;
	logic [1:0] host_mode_o;
	logic [31:0] lfsr = 32'hdadd;
	logic [31:0] rd;
	logic err;
	int n;
	int n_mismatch = 0;
	int total_checks = 0;

	always #12.5 sys_clk_i = ~sys_clk_i;

	stc_trigger_ctrl dut (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.psel_i(req.psel),
		.penable_i(req.penable),
		.pwrite_i(req.pwrite),
		.paddr_i(req.paddr),
		.pwdata_i(req.pwdata),
		.prdata_o(prdata_o),
		.pready_o(pready_o),
		.pslverr_o(pslverr_o),
		.scan_request_pin_n_i(pin_n),
		.decode_good_i(decode_good_i),
		.decode_error_i(decode_error_i),
		.session_active_o(session_active_o),
		.illumination_o(illumination_o),
		.audible_pwm_out_o(pwm),
		.good_read_indicator_a_o(ind_a),
		.good_read_indicator_b_o(ind_b),
		.host_mode_o(host_mode_o)
	);

	stc_host_model host (
		.sys_clk_i(sys_clk_i),
		.scan_request_pin_n_o(pin_n)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// One APB transfer, ends at the edge where pready is sampled
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		@(posedge sys_clk_i);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge sys_clk_i);
		req.penable <= 1'b1;
		k = 0;
		do begin
			@(posedge sys_clk_i);
			k++;
		end while (pready_o !== 1'b1 && k < 20);
		if (pready_o !== 1'b1) begin
			n_mismatch++;
			end_sim();
		end
		rd = prdata_o;
		err = pslverr_o;
		req <= '0;
	endtask : apb

	// Count edges until the session output reaches a level
	task automatic wait_sess(input logic lvl, input int bound, output int cnt);
		cnt = 0;
		while (session_active_o !== lvl) begin
			@(posedge sys_clk_i);
			cnt++;
			if (cnt > bound) begin
				n_mismatch++;
				end_sim();
			end
		end
	endtask : wait_sess

	task automatic pulse_good();
		decode_good_i <= 1'b1;
		@(posedge sys_clk_i);
		decode_good_i <= 1'b0;
	endtask : pulse_good

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		for (int l = 1; l >= 0; l--) begin
			n = 0;
			while (pwm !== l[0] && n < TONE_CYCLES) begin
				@(posedge sys_clk_i);
				n++;
			end
			check("power-up tone", pwm, l[0]);
		end
		check("indicator idle", {ind_a, ind_b}, 2'b00);
		apb(1'b0, CTRL_OFS, 32'h0);
		check("ctrl reset", rd, CTRL_RESET);
		apb(1'b0, TIMEOUT_OFS, 32'h0);
		check("timeout reset", rd, SESSION_CYCLES);
		apb(1'b0, 12'h014, 32'h0);
		check("unmapped error", err, 1'b1);
		apb(1'b1, QUAL_OFS, 32'h0);
		apb(1'b0, QUAL_OFS, 32'h0);
		check("qual zero refused", rd, QUAL_CYCLES);
		apb(1'b1, QUAL_OFS, Q);
		apb(1'b1, TIMEOUT_OFS, T);
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, CTRL_OFS, {28'h0, m[1:0], 2'b01});
			repeat (2) @(posedge sys_clk_i);
			check("host mode", host_mode_o, (m == 3) ? 2'd2 : m[1:0]);
		end
		for (int i = 0; i < 3; i++) begin
			lfsr = lfsr_next(lfsr);
			host.hold(1'b0, 1 + lfsr % (Q - 4));
			host.hold(1'b1, 2);
			check("short pulse", session_active_o, 1'b0);
			host.hold(1'b1, Q + 6);
			check("short pulse settled", session_active_o, 1'b0);
		end
		host.hold(1'b0, 0);
		wait_sess(1'b1, 4 * Q, n);
		check("trigger delay", (n >= Q && n <= Q + 6), 1'b1);
		@(posedge sys_clk_i);
		check("illumination on", illumination_o, 1'b1);
		pulse_good();
		repeat (4) @(posedge sys_clk_i);
		check("indicator burst", ind_a, 1'b1);
		check("indicator pair", ind_b, ind_a);
		check("one session", session_active_o, 1'b0);
		repeat (3 * Q) @(posedge sys_clk_i);
		check("held low no rearm", session_active_o, 1'b0);
		host.hold(1'b1, 5);
		host.hold(1'b0, 3 * Q);
		check("short release", session_active_o, 1'b0);
		host.hold(1'b1, Q + 6);
		apb(1'b1, CTRL_OFS, 32'h2);
		host.hold(1'b0, 0);
		wait_sess(1'b1, 4 * Q, n);
		check("rearm after release", (n >= Q && n <= Q + 6), 1'b1);
		@(posedge sys_clk_i);
		check("illumination off", illumination_o, 1'b0);
		decode_error_i <= 1'b1;
		@(posedge sys_clk_i);
		decode_error_i <= 1'b0;
		wait_sess(1'b0, T + 50, n);
		check("session timeout", (n >= T - 8 && n <= T + 4), 1'b1);
		// Third session: status readback, then software end event
		host.hold(1'b1, Q + 6);
		host.hold(1'b0, 0);
		wait_sess(1'b1, 4 * Q, n);
		check("rearm after timeout", (n >= Q && n <= Q + 6), 1'b1);
		apb(1'b0, STATUS_OFS, 32'h0);
		check("status in session", rd, 32'h0000_0003);
		check("status no error", err, 1'b0);
		apb(1'b1, EVENT_OFS, 32'h0000_0004);
		wait_sess(1'b0, 8, n);
		check("event ends session", (n <= 4), 1'b1);
		host.hold(1'b1, Q);
		end_sim();
	end

endmodule : tb_top
`default_nettype wire

//--- hw/stc_beeper.sv
// PWM tone generator for audible feedback
`timescale 1ns/1ps
`default_nettype none
module stc_beeper import stc_pkg::*; (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire stc_tone_type tone_i,
	output logic busy_o,
	output logic pwm_o
);

	// ----------------------------------------
	// Tone pattern state
	// ----------------------------------------
	localparam logic [15:0] HIGH_CYC = 16'(TONE_CYCLES * TONE_DUTY_PCT / 100);
	localparam logic [15:0] PER_CYC = 16'(TONE_CYCLES);
	localparam logic [31:0] BEEP_LEN = 32'(BEEP_CYCLES);

	logic [15:0] phase, next_phase;
	logic [31:0] dur, next_dur;
	logic [1:0] beeps, next_beeps;
	logic gap, next_gap;
	logic pwm, next_pwm;

	always_comb begin
		next_phase = phase;
		next_dur = dur;
		next_beeps = beeps;
		next_gap = gap;
		next_pwm = 1'b0;
		if (tone_i != TONE_NONE && beeps == 2'd0) begin
			// Power up: three beeps, good: one, error: two
			case (tone_i)
				TONE_POWER_UP: next_beeps = 2'd3;
				TONE_GOOD: next_beeps = 2'd1;
				TONE_ERROR: next_beeps = 2'd2;
				default: next_beeps = 2'd0;
			endcase
			next_dur = BEEP_LEN;
			next_gap = 1'b0;
			next_phase = 16'h0000;
		end else if (beeps != 2'd0) begin
			next_phase = (phase + 16'h0001 >= PER_CYC) ? 16'h0000 : phase + 16'h0001;
			next_pwm = !gap && (phase < HIGH_CYC);
			if (dur <= 32'h0000_0001) begin
				next_dur = BEEP_LEN;
				next_gap = !gap;
				if (!gap) begin
					next_beeps = beeps - 2'd1;
				end
			end else begin
				next_dur = dur - 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			phase <= 16'h0000;
			dur <= 32'h0000_0000;
			beeps <= 2'd0;
			gap <= 1'b0;
			pwm <= 1'b0;
		end else begin
			phase <= next_phase;
			dur <= next_dur;
			beeps <= next_beeps;
			gap <= next_gap;
			pwm <= next_pwm;
		end
	end

	assign busy_o = (beeps != 2'd0);
	assign pwm_o = pwm;

endmodule : stc_beeper
`default_nettype wire

//--- hw/stc_pkg.sv
// Package of constants, types and register map for the scan trigger control
package stc_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 40000000;
	localparam int unsigned QUAL_TIME_MS = 10;
	localparam int unsigned QUAL_CYCLES = CLK_HZ / 1000 * QUAL_TIME_MS;
	localparam int unsigned SESSION_TIME_MS = 3000;
	localparam int unsigned SESSION_CYCLES = CLK_HZ / 1000 * SESSION_TIME_MS;
	localparam int unsigned TONE_HZ = 2700;
	localparam int unsigned TONE_CYCLES = CLK_HZ / TONE_HZ;
	localparam int unsigned TONE_DUTY_PCT = 50;
	localparam int unsigned BEEP_TIME_MS = 100;
	localparam int unsigned BEEP_CYCLES = CLK_HZ / 1000 * BEEP_TIME_MS;
	localparam int unsigned BLINK_TIME_MS = 50;
	localparam int unsigned BLINK_CYCLES = CLK_HZ / 1000 * BLINK_TIME_MS;
	localparam int unsigned BLINK_TOGGLES = 6;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] STATUS_OFS = 12'h004;
	localparam logic [11:0] EVENT_OFS = 12'h008;
	localparam logic [11:0] QUAL_OFS = 12'h00c;
	localparam logic [11:0] TIMEOUT_OFS = 12'h010;

	// ----------------------------------------
	// Control fields
	// ----------------------------------------
	localparam int unsigned CTRL_ILLUM_BIT = 0;
	localparam int unsigned CTRL_TIMED_BIT = 1;
	localparam int unsigned CTRL_HOST_LSB = 2;
	localparam int unsigned EV_GOOD_BIT = 0;
	localparam int unsigned EV_ERROR_BIT = 1;
	localparam int unsigned EV_DONE_BIT = 2;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0003;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		HOST_UART_SERIAL,
		HOST_KEYBOARD_EMULATION_MODE,
		HOST_USB_SERIAL
	} stc_host_mode_type;

	typedef enum logic [1:0] {
		TONE_NONE,
		TONE_POWER_UP,
		TONE_GOOD,
		TONE_ERROR
	} stc_tone_type;

	typedef struct packed {
		logic illum_enable;
		logic timed_mode;
		stc_host_mode_type host_mode;
		logic [31:0] qual_cycles;
		logic [31:0] session_cycles;
	} stc_cfg_type;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} stc_apb_req_type;

endpackage : stc_pkg

//--- hw/stc_trigger_ctrl.sv
// Trigger, session, indicator, illumination and register control
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module stc_trigger_ctrl import stc_pkg::*; (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic scan_request_pin_n_i,
	input wire logic decode_good_i,
	input wire logic decode_error_i,
	output logic session_active_o,
	output logic illumination_o,
	output logic audible_pwm_out_o,
	output logic good_read_indicator_a_o,
	output logic good_read_indicator_b_o,
	output logic [1:0] host_mode_o
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic is_reg(input logic [11:0] a, input logic [11:0] o);
		is_reg = (a == o);
	endfunction : is_reg

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	stc_apb_req_type req;
	stc_cfg_type cfg, next_cfg;
	logic [31:0] rdata, next_rdata;
	logic ready, next_ready;
	logic slverr, next_slverr;
	logic [2:0] sw_event;
	logic [2:0] ev_pulse, next_ev_pulse;
	logic sess, press_ok, rel_ok;

	assign req = '{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i};

	always_comb begin
		next_cfg = cfg;
		next_rdata = 32'h0000_0000;
		next_ready = 1'b0;
		next_slverr = 1'b0;
		next_ev_pulse = 3'b000;
		if (req.psel && req.penable && !ready) begin
			next_ready = 1'b1;
			if (is_reg(req.paddr, CTRL_OFS)) begin
				if (req.pwrite) begin
					next_cfg.illum_enable = req.pwdata[CTRL_ILLUM_BIT];
					next_cfg.timed_mode = req.pwdata[CTRL_TIMED_BIT];
					if (req.pwdata[CTRL_HOST_LSB +: 2] != 2'd3) begin
						next_cfg.host_mode =
							stc_host_mode_type'(req.pwdata[CTRL_HOST_LSB +: 2]);
					end
				end
				next_rdata = {28'h0000_000, cfg.host_mode, cfg.timed_mode,
					cfg.illum_enable};
			end else if (is_reg(req.paddr, STATUS_OFS)) begin
				next_rdata = {29'h0000_000, rel_ok, press_ok, sess};
			end else if (is_reg(req.paddr, EVENT_OFS)) begin
				if (req.pwrite) begin
					next_ev_pulse = req.pwdata[2:0];
				end
			end else if (is_reg(req.paddr, QUAL_OFS)) begin
				if (req.pwrite && req.pwdata != 32'h0000_0000) begin
					next_cfg.qual_cycles = req.pwdata;
				end
				next_rdata = cfg.qual_cycles;
			end else if (is_reg(req.paddr, TIMEOUT_OFS)) begin
				if (req.pwrite && req.pwdata != 32'h0000_0000) begin
					next_cfg.session_cycles = req.pwdata;
				end
				next_rdata = cfg.session_cycles;
			end else begin
				next_slverr = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			cfg <= '{CTRL_RESET[CTRL_ILLUM_BIT], CTRL_RESET[CTRL_TIMED_BIT],
				HOST_UART_SERIAL, QUAL_CYCLES, SESSION_CYCLES};
			rdata <= 32'h0000_0000;
			ready <= 1'b0;
			slverr <= 1'b0;
			ev_pulse <= 3'b000;
		end else begin
			cfg <= next_cfg;
			rdata <= next_rdata;
			ready <= next_ready;
			slverr <= next_slverr;
			ev_pulse <= next_ev_pulse;
		end
	end

	assign sw_event = ev_pulse;

	// ----------------------------------------
	// Synchroniser and debounce
	// ----------------------------------------
	logic sync_a, sync_b;
	logic [31:0] low_cnt, next_low_cnt;
	logic [31:0] high_cnt, next_high_cnt;
	logic next_press_ok, next_rel_ok;

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			sync_a <= 1'b1;
			sync_b <= 1'b1;
		end else begin
			sync_a <= scan_request_pin_n_i;
			sync_b <= sync_a;
		end
	end

	always_comb begin
		next_low_cnt = 32'h0000_0000;
		next_high_cnt = 32'h0000_0000;
		if (!sync_b) begin
			next_low_cnt = (low_cnt < cfg.qual_cycles) ? low_cnt + 32'h1 : low_cnt;
		end else begin
			next_high_cnt = (high_cnt < cfg.qual_cycles) ? high_cnt + 32'h1 : high_cnt;
		end
		next_press_ok = (next_low_cnt >= cfg.qual_cycles);
		next_rel_ok = (next_high_cnt >= cfg.qual_cycles);
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			low_cnt <= 32'h0000_0000;
			high_cnt <= 32'h0000_0000;
			press_ok <= 1'b0;
			rel_ok <= 1'b0;
		end else begin
			low_cnt <= next_low_cnt;
			high_cnt <= next_high_cnt;
			press_ok <= next_press_ok;
			rel_ok <= next_rel_ok;
		end
	end

	// ----------------------------------------
	// Session control
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_WAIT_RELEASE,
		ST_ARMED,
		ST_SESSION,
		ST_HELD
	} stc_sess_state_type;

	stc_sess_state_type state, next_state;
	logic [31:0] sess_cnt, next_sess_cnt;
	logic done_evt;

	assign done_evt = decode_good_i || sw_event[EV_DONE_BIT]
		|| sw_event[EV_GOOD_BIT];

	always_comb begin
		next_state = state;
		next_sess_cnt = sess_cnt;
		case (state)
			ST_WAIT_RELEASE: begin
				if (rel_ok) begin
					next_state = ST_ARMED;
				end
			end
			ST_ARMED: begin
				if (press_ok) begin
					next_state = ST_SESSION;
					next_sess_cnt = cfg.session_cycles;
				end
			end
			ST_SESSION: begin
				next_sess_cnt = sess_cnt - 32'h1;
				if (done_evt || !press_ok) begin
					next_state = ST_WAIT_RELEASE;
				end else if (cfg.timed_mode && sess_cnt <= 32'h1) begin
					next_state = ST_HELD;
				end
			end
			ST_HELD: begin
				next_state = ST_WAIT_RELEASE;
			end
			default: next_state = ST_WAIT_RELEASE;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			state <= ST_WAIT_RELEASE;
			sess_cnt <= 32'h0000_0000;
		end else begin
			state <= next_state;
			sess_cnt <= next_sess_cnt;
		end
	end

	assign sess = (state == ST_SESSION);

	// ----------------------------------------
	// Indicator burst
	// ----------------------------------------
	localparam logic [3:0] BURST_LEN = 4'(BLINK_TOGGLES);
	localparam logic [31:0] BLINK_LEN = 32'(BLINK_CYCLES);
	logic [3:0] toggles, next_toggles;
	logic [31:0] blink_cnt, next_blink_cnt;
	logic ind, next_ind;
	logic good_evt;

	assign good_evt = decode_good_i || sw_event[EV_GOOD_BIT];

	always_comb begin
		next_toggles = toggles;
		next_blink_cnt = blink_cnt;
		next_ind = ind;
		if (good_evt && toggles == 4'h0) begin
			next_toggles = BURST_LEN;
			next_blink_cnt = BLINK_LEN;
			next_ind = 1'b1;
		end else if (toggles != 4'h0) begin
			if (blink_cnt <= 32'h1) begin
				next_blink_cnt = BLINK_LEN;
				next_toggles = toggles - 4'h1;
				next_ind = (toggles == 4'h1) ? 1'b0 : !ind;
			end else begin
				next_blink_cnt = blink_cnt - 32'h1;
			end
		end else begin
			next_ind = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			toggles <= 4'h0;
			blink_cnt <= 32'h0000_0000;
			ind <= 1'b0;
		end else begin
			toggles <= next_toggles;
			blink_cnt <= next_blink_cnt;
			ind <= next_ind;
		end
	end

	// ----------------------------------------
	// Audible feedback
	// ----------------------------------------
	stc_tone_type tone, next_tone;
	logic pwr_up, next_pwr_up;
	logic beep_busy, beep_pwm;

	always_comb begin
		next_pwr_up = 1'b1;
		next_tone = TONE_NONE;
		if (!pwr_up) begin
			next_tone = TONE_POWER_UP;
		end else if (good_evt) begin
			next_tone = TONE_GOOD;
		end else if (decode_error_i || sw_event[EV_ERROR_BIT]) begin
			next_tone = TONE_ERROR;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			pwr_up <= 1'b0;
			tone <= TONE_NONE;
		end else begin
			pwr_up <= next_pwr_up;
			tone <= next_tone;
		end
	end

	stc_beeper u_beeper (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.tone_i(tone),
		.busy_o(beep_busy),
		.pwm_o(beep_pwm)
	);

	// ----------------------------------------
	// Output registers
	// ----------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			session_active_o <= 1'b0;
			illumination_o <= 1'b0;
			audible_pwm_out_o <= 1'b0;
			good_read_indicator_a_o <= 1'b0;
			good_read_indicator_b_o <= 1'b0;
			host_mode_o <= 2'd0;
		end else begin
			session_active_o <= sess;
			illumination_o <= sess && cfg.illum_enable;
			audible_pwm_out_o <= beep_pwm && beep_busy;
			good_read_indicator_a_o <= ind;
			good_read_indicator_b_o <= ind;
			host_mode_o <= cfg.host_mode;
		end
	end

	assign prdata_o = rdata;
	assign pready_o = ready;
	assign pslverr_o = slverr;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_short_low_filtered: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		$rose(press_ok) |-> low_cnt >= cfg.qual_cycles - 32'h1)
		else $error("Trigger qualified too early");
	a_start_needs_press: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		$rose(sess) |-> $past(press_ok) && $past(state) == ST_ARMED)
		else $error("Session started without qualified trigger");
	a_rearm_needs_high: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		state == ST_WAIT_RELEASE ##1 state == ST_ARMED |-> $past(rel_ok))
		else $error("Rearmed without release time");
	a_timeout_ends: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		sess && cfg.timed_mode && sess_cnt == 32'h1 |=> !sess)
		else $error("Session not ended on timeout");
	a_one_session: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		$fell(sess) |-> ##1 state != ST_SESSION)
		else $error("Session restarted without rearm");
	a_sync_order: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		##2 sync_b == $past(scan_request_pin_n_i, 2))
		else $error("Synchroniser depth wrong");
	a_burst_toggles: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		good_read_indicator_a_o |-> $past(toggles) != 4'h0
			&& good_read_indicator_b_o)
		else $error("Indicator high outside burst");
	a_illum_gate: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		!cfg.illum_enable ##1 !cfg.illum_enable |-> !illumination_o)
		else $error("Illumination on while disabled");
	a_tone_start: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		$rose(pwr_up) |-> tone == TONE_POWER_UP)
		else $error("No power-up tone");
	a_host_mode: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		##1 host_mode_o != 2'd3)
		else $error("Illegal host mode");

endmodule : stc_trigger_ctrl
`default_nettype wire
